// ==== design/tws_slave_rx.sv ====
// two-wire slave receiver with AXI4-Lite register access
//
// Contract
// - upper seven own-address bits are the slave address answered.
// - own-address bit 0 enables answering general call address 0x00.
// - after a match, direction bit 0 selects receive; 1 selects transmit; the code leaves a read unacknowledged and goes idle.
// - own address plus write bit received sets flag and posts valid status.
// - lost arbitration then addressed for writing enters receive, status 0x68/0x78.
// - ack-enable cleared mid-transfer gives NOT ACK after next data byte.
// - ack-enable zero ignores own address; bus still monitored for resumption.
// - outside idle sleep the system clock to the interface is stopped.
// - asleep with ack-enable set, address still acknowledged from bus clock.
// - match in sleep wakes, SCL held low until flag cleared by one.
// - after sleep wake the data register need not hold last bus byte.
// - status 0x60 for own address with write bit acknowledged.
// - status 0x68 for arbitration lost then own address write acknowledged.
// - status 0x70 for general call address acknowledged.
// - status 0x78 for arbitration lost then general call acknowledged.
// - flag cleared in 0x60-0x80 receives next byte, ACK per ack-enable.
// - status 0x80 for data byte acknowledged; byte readable in data register.
// - after 0x88, clearing with ack-enable zero recognises no address.
// - after 0x88 with ack-enable one, own address on, general call if enabled.
// - not-addressed response with start request sends START when bus free; the code launches it only after status 0xA0.
// - general call data byte gives status 0x90 on ACK, 0x98 on NOT ACK.
// - STOP or repeated START while addressed gives 0xA0, then not addressed.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "tws_defines.svh"

module tws_slave_rx
  import tws_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // two-wire bus pins, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // neighbouring logic
  input wire logic arb_lost,
  input wire logic sleep_mode,
  output logic wake_req,
  output logic irq_request,
  output logic start_launch
);

  // ****************************************
  // declarations
  // ****************************************
  tws_state_e state;
  tws_next_e hold_next;
  logic [7:0] status_reg;
  logic [7:0] data_reg;
  logic [7:0] own_address_reg;
  logic irq_flag, ack_enable, start_request, stop_request, write_collision, iface_enable, irq_enable;
  logic [1:0] scl_sync, sda_sync;
  logic scl_prev, sda_prev;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic gc_mode, arb_pending, ack_sel, bus_busy, start_pend;
  logic aw_got, w_got;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane;

  // ****************************************
  // pin synchronisers and bus condition detection
  // ****************************************
  // two flops before anything looks at the pins; the link clock is just sampled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_prev;
  wire scl_fall = ~scl_s & scl_prev;
  wire start_cond = scl_s & scl_prev & sda_prev & ~sda_s;
  wire stop_cond = scl_s & scl_prev & ~sda_prev & sda_s;

  // ****************************************
  // address decode for the receive engine
  // ****************************************
  wire [7:0] addr_byte = shift;
  wire own_match = (addr_byte[7:1] == own_address_reg[7:1]);
  wire gc_match = (addr_byte[7:1] == `TWS_GENERAL_CALL_ADDRESS) & own_address_reg[0];
  // ack-enable gates recognition; monitoring goes on regardless so it resumes at once
  wire addr_hit = iface_enable & ack_enable & (own_match | gc_match);
  wire write_dir = ~addr_byte[0];
  wire addressed = (state == TWS_DATA) | (state == TWS_DATA_ACK) | (state == TWS_HOLD);
  wire [7:0] addr_status = gc_match & ~own_match ?
    (arb_pending ? `TWS_ST_ARB_GC_ACK : `TWS_ST_GC_ACK) :
    (arb_pending ? `TWS_ST_ARB_OWN_W_ACK : `TWS_ST_OWN_W_ACK);
  wire [7:0] data_status = gc_mode ?
    (ack_sel ? `TWS_ST_GC_DATA_ACK : `TWS_ST_GC_DATA_NACK) :
    (ack_sel ? `TWS_ST_DATA_ACK : `TWS_ST_DATA_NACK);
  wire hw_set_flag = (state == TWS_ADDR_ACK & scl_fall) | (state == TWS_DATA_ACK & scl_fall) |
    (addressed & state != TWS_HOLD & (stop_cond | start_cond));

  // ****************************************
  // receive engine
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= TWS_IDLE;
      hold_next <= TWS_NEXT_IDLE;
      shift <= `TWS_RST_BYTE;
      bit_cnt <= 4'h0;
      gc_mode <= 1'b0;
      ack_sel <= 1'b0;
      status_reg <= `TWS_ST_NO_INFO;
    end else if (!iface_enable) begin
      state <= TWS_IDLE;
      status_reg <= `TWS_ST_NO_INFO;
    end else if (addressed & state != TWS_HOLD & (stop_cond | start_cond)) begin
      // stop or repeated start while still addressed
      status_reg <= `TWS_ST_STOP_RSTART;
      hold_next <= start_cond ? TWS_NEXT_ADDR : TWS_NEXT_IDLE;
      state <= TWS_HOLD;
    end else if (start_cond & state != TWS_HOLD) begin
      state <= TWS_ADDR;
      bit_cnt <= 4'h0;
    end else if (stop_cond & state != TWS_HOLD) begin
      state <= TWS_IDLE;
    end else begin
      unique case (state)
        TWS_IDLE: begin
          bit_cnt <= 4'h0;
        end
        TWS_ADDR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            // a read request belongs to transmit mode, which is not here
            if (addr_hit && write_dir) begin
              state <= TWS_ADDR_ACK;
              gc_mode <= gc_match & ~own_match;
            end else begin
              state <= TWS_IDLE;
            end
          end
        end
        TWS_ADDR_ACK: begin
          if (scl_fall) begin
            status_reg <= addr_status;
            hold_next <= TWS_NEXT_DATA;
            state <= TWS_HOLD;
          end
        end
        TWS_HOLD: begin
          // software answers by clearing the flag; ack-enable is sampled then
          if (!irq_flag) begin
            ack_sel <= ack_enable;
            bit_cnt <= 4'h0;
            status_reg <= `TWS_ST_NO_INFO;
            if (hold_next == TWS_NEXT_DATA && !stop_request && status_reg != `TWS_ST_DATA_NACK &&
                status_reg != `TWS_ST_GC_DATA_NACK) begin
              state <= TWS_DATA;
            end else if (hold_next == TWS_NEXT_ADDR) begin
              state <= TWS_ADDR;
            end else begin
              state <= TWS_IDLE;
            end
          end
        end
        TWS_DATA: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            state <= TWS_DATA_ACK;
          end
        end
        TWS_DATA_ACK: begin
          if (scl_fall) begin
            status_reg <= data_status;
            hold_next <= TWS_NEXT_DATA;
            state <= TWS_HOLD;
          end
        end
        default: begin
          state <= TWS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // a nack is simply sda left released, which reads as one
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = (state == TWS_ADDR_ACK) | (state == TWS_DATA_ACK & ack_sel);
  // holding scl through a long wake-up blocks every other master on the bus
  assign scl_oe = (state == TWS_HOLD) & irq_flag;

  // ****************************************
  // arbitration loss, bus free and start launch
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arb_pending <= 1'b0;
      bus_busy <= 1'b0;
      start_pend <= 1'b0;
    end else begin
      if (arb_lost) begin
        arb_pending <= 1'b1;
      end else if (state == TWS_ADDR_ACK && scl_fall) begin
        arb_pending <= 1'b0;
      end else if (stop_cond) begin
        arb_pending <= 1'b0;
      end
      if (start_cond) begin
        bus_busy <= 1'b1;
      end else if (stop_cond) begin
        bus_busy <= 1'b0;
      end
      if (state == TWS_HOLD && !irq_flag && hold_next != TWS_NEXT_DATA && start_request) begin
        start_pend <= 1'b1;
      end else if (start_launch) begin
        start_pend <= 1'b0;
      end
    end
  end

  // one pulse to the master logic once the bus is seen free
  assign start_launch = start_pend & ~bus_busy & (state == TWS_IDLE);

  // ****************************************
  // axi4-lite decode
  // ****************************************
  wire wr_fire = aw_got & w_got & ~s_axi_bvalid;
  wire wr_ctl = wr_fire & w_lane & (aw_addr == `TWS_OFS_CONTROL);
  wire wr_data = wr_fire & w_lane & (aw_addr == `TWS_OFS_DATA);
  wire wr_own = wr_fire & w_lane & (aw_addr == `TWS_OFS_OWN_ADDR);
  wire wr_mapped = (aw_addr == `TWS_OFS_CONTROL) | (aw_addr == `TWS_OFS_STATUS) |
    (aw_addr == `TWS_OFS_DATA) | (aw_addr == `TWS_OFS_OWN_ADDR);
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  wire [7:0] ctl_value = {irq_flag, ack_enable, start_request, stop_request, write_collision,
    iface_enable, 1'b0, irq_enable};
  wire rd_ctl = (s_axi_araddr == `TWS_OFS_CONTROL);
  wire rd_sts = (s_axi_araddr == `TWS_OFS_STATUS);
  wire rd_dat = (s_axi_araddr == `TWS_OFS_DATA);
  wire rd_own = (s_axi_araddr == `TWS_OFS_OWN_ADDR);
  wire [7:0] rd_byte = rd_ctl ? ctl_value : rd_sts ? status_reg : rd_dat ? data_reg :
    rd_own ? own_address_reg : `TWS_RST_BYTE;
  wire rd_mapped = rd_ctl | rd_sts | rd_dat | rd_own;

  assign s_axi_awready = ~aw_got;
  assign s_axi_wready = ~w_got;
  assign s_axi_arready = ~s_axi_rvalid;

  // ****************************************
  // axi4-lite channel handshakes
  // ****************************************
  // address and data are latched separately so either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= `TWS_RST_BYTE;
      w_byte <= `TWS_RST_BYTE;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TWS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_got) begin
        aw_got <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_got) begin
        w_got <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TWS_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_mapped ? `TWS_RESP_OKAY : `TWS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // control, data and own-address registers
  // ****************************************
  // hardware setting the flag outranks a write of one in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag <= 1'b0;
      ack_enable <= 1'b0;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      write_collision <= 1'b0;
      iface_enable <= 1'b0;
      irq_enable <= 1'b0;
      own_address_reg <= `TWS_RST_BYTE;
    end else begin
      if (hw_set_flag) begin
        irq_flag <= 1'b1;
      end else if (wr_ctl && w_byte[`TWS_CTL_IRQ_FLAG]) begin
        irq_flag <= 1'b0;
      end
      if (wr_ctl) begin
        ack_enable <= w_byte[`TWS_CTL_ACK_ENABLE];
        iface_enable <= w_byte[`TWS_CTL_IFACE_ENABLE];
        irq_enable <= w_byte[`TWS_CTL_IRQ_ENABLE];
        stop_request <= w_byte[`TWS_CTL_STOP_REQUEST];
      end else if (state == TWS_HOLD && !irq_flag) begin
        stop_request <= 1'b0;
      end
      if (wr_ctl) begin
        start_request <= w_byte[`TWS_CTL_START_REQUEST];
      end else if (start_launch) begin
        start_request <= 1'b0;
      end
      // writing data while the flag is low is a collision; clearing is by a data write with flag high
      if (wr_data && !irq_flag) begin
        write_collision <= 1'b1;
      end else if (wr_data) begin
        write_collision <= 1'b0;
      end
      if (wr_own) begin
        own_address_reg <= w_byte;
      end
    end
  end

  // received byte lands on the ack edge; while asleep the store is skipped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_reg <= `TWS_RST_BYTE;
    end else if (state == TWS_DATA_ACK && scl_fall && !sleep_mode) begin
      data_reg <= shift;
    end else if (wr_data && irq_flag) begin
      data_reg <= w_byte;
    end
  end

  // ****************************************
  // sleep wake and interrupt request
  // ****************************************
  // in deep sleep the whole receive engine keeps running and only the data-register store is skipped; a flagged event asks for the clocks back
  assign wake_req = sleep_mode & irq_flag;
  assign irq_request = irq_flag & irq_enable;

endmodule // tws_slave_rx

// ==== design/tws_defines.svh ====
// register map, field positions, reset values and status codes of the two-wire slave receiver
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TWS_OFS_CONTROL 8'h00
`define TWS_OFS_STATUS 8'h04
`define TWS_OFS_DATA 8'h08
`define TWS_OFS_OWN_ADDR 8'h0C

// ****************************************
// control register fields
// ****************************************
`define TWS_CTL_IRQ_FLAG 7
`define TWS_CTL_ACK_ENABLE 6
`define TWS_CTL_START_REQUEST 5
`define TWS_CTL_STOP_REQUEST 4
`define TWS_CTL_WRITE_COLLISION 3
`define TWS_CTL_IFACE_ENABLE 2
`define TWS_CTL_IRQ_ENABLE 0

// ****************************************
// reset values and bus answers
// ****************************************
`define TWS_RST_BYTE 8'h00
`define TWS_GENERAL_CALL_ADDRESS 7'h00
`define TWS_RESP_OKAY 2'b00
`define TWS_RESP_SLVERR 2'b10

// ****************************************
// status codes, prescaler bits read as zero
// ****************************************
`define TWS_ST_OWN_W_ACK 8'h60
`define TWS_ST_ARB_OWN_W_ACK 8'h68
`define TWS_ST_GC_ACK 8'h70
`define TWS_ST_ARB_GC_ACK 8'h78
`define TWS_ST_DATA_ACK 8'h80
`define TWS_ST_DATA_NACK 8'h88
`define TWS_ST_GC_DATA_ACK 8'h90
`define TWS_ST_GC_DATA_NACK 8'h98
`define TWS_ST_STOP_RSTART 8'hA0
`define TWS_ST_NO_INFO 8'hF8

`endif

// ==== design/tws_pkg.sv ====
// types shared by the two-wire slave receiver
package tws_pkg;

  // ****************************************
  // receive engine states
  // ****************************************
  typedef enum logic [2:0] {
    TWS_IDLE,
    TWS_ADDR,
    TWS_ADDR_ACK,
    TWS_HOLD,
    TWS_DATA,
    TWS_DATA_ACK
  } tws_state_e;

  // ****************************************
  // what follows once software clears the flag
  // ****************************************
  typedef enum logic [1:0] {
    TWS_NEXT_DATA,
    TWS_NEXT_IDLE,
    TWS_NEXT_ADDR
  } tws_next_e;

endpackage

// ==== sim/tws_checker.sv ====
// concurrent checks on the ports of the two-wire slave receiver
`timescale 1ns/100ps
module tws_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic sleep_mode,
  input wire logic wake_req,
  input wire logic start_launch
);
  // ****************************************
  // one clock domain, so clock and reset are given once
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // handshakes that start a register access
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answered: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing two cycles after write");
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before it was taken");
  a_read_answered: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer missing one cycle after request");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  // an ack edge while scl is high would look like a start or stop
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_stretch_no_ack: assert property (scl_oe |-> !sda_oe)
    else $error("sda driven while scl stretched");
  a_wake_in_sleep: assert property (wake_req |-> sleep_mode)
    else $error("wake request outside sleep");
  a_wake_with_stretch: assert property (wake_req |-> scl_oe)
    else $error("scl not held while waking");
  a_launch_pulse: assert property (start_launch |=> !start_launch)
    else $error("start launch longer than one cycle");
endmodule // tws_checker

bind tws_slave_rx tws_checker i_tws_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .scl_i(scl_i), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .sleep_mode(sleep_mode), .wake_req(wake_req), .start_launch(start_launch)
);

// ==== sim/tws_master_model.sv ====
// behavioural two-wire bus master transmitter on the far side of the link
`timescale 1ns/100ps
module tws_master_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  // ****************************************
  // link clock stands still high between frames
  // ****************************************
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // the slave may stretch scl, so the high phase starts when the line rises
  task automatic scl_rise();
    scl_drv = 1'b1;
    while (!scl_line) #25;
  endtask
  // data changes a little after scl falls so it never races the clock edge
  task automatic bit_clk(input logic b, output logic seen);
    #25 sda_drv = b;
    #75 scl_rise();
    #50 seen = sda_line;
    #50 scl_drv = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(b[i], x); // msb first
    end
    bit_clk(1'b1, ack); // released so the slave answers
  endtask
  task automatic start();
    #100 sda_drv = 1'b0;
    #100 scl_drv = 1'b0;
  endtask
  task automatic stop();
    #25 sda_drv = 1'b0;
    #75 scl_rise();
    #100 sda_drv = 1'b1;
    #100;
  endtask
endmodule // tws_master_model

// ==== sim/tb.sv ====
// self-checking bench for the two-wire slave receiver
`timescale 1ns/100ps
`include "tws_defines.svh"
module tb;
  localparam logic [31:0] C_RUN = 32'h0000_0045;
  localparam logic [31:0] C_ACK = 32'h0000_00C5;
  localparam logic [31:0] C_NACK = 32'h0000_0085;
  localparam logic [31:0] C_START = 32'h0000_00E5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic arb_lost = 1'b0, sleep_mode = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ack;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic scl_o, scl_oe, sda_o, sda_oe, wake_req, irq_request, start_launch, m_scl, m_sda;
  int failures = 0, check_count = 0, cycles = 0, launches = 0;
  // ****************************************
  // open-drain lines with pull-ups
  // ****************************************
  wire logic scl_i = m_scl & ~(scl_oe & ~scl_o);
  wire logic sda_i = m_sda & ~(sda_oe & ~sda_o);
  tws_slave_rx i_tws_slave_rx (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .arb_lost(arb_lost), .sleep_mode(sleep_mode),
    .wake_req(wake_req), .irq_request(irq_request), .start_launch(start_launch));
  tws_master_model i_tws_master_model (.scl_line(scl_i), .sda_line(sda_i), .scl_drv(m_scl), .sda_drv(m_sda));
  always #12.5 aclk = ~aclk;
  // cycle count cuts a hang short; launch pulses are tallied here
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (start_launch === 1'b1) launches = launches + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic sw(input logic [31:0] c);
    axi_wr(`TWS_OFS_CONTROL, c, rsp);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rsp);
    chk(name, rd, exp);
  endtask
  task automatic open_addr(input logic [7:0] b, input logic exp);
    i_tws_master_model.start();
    i_tws_master_model.send_byte(b, ack);
    chk("address ack", ack, exp);
  endtask
  // software answers alongside the byte; the flag clears before the master first lets scl rise
  task automatic data_byte(input logic [7:0] b, input logic [31:0] c, input logic exp);
    fork
      i_tws_master_model.send_byte(b, ack);
      sw(c);
    join
    chk("data ack", ack, exp);
  endtask
  task automatic stop_clear(input logic [31:0] c);
    fork
      i_tws_master_model.stop();
      sw(c);
    join
  endtask
  task automatic post(input logic [7:0] st);
    while (irq_request !== 1'b1) @(posedge aclk);
    rd_chk("status", `TWS_OFS_STATUS, st);
  endtask
  task automatic pulse_arb();
    @(posedge aclk);
    arb_lost <= 1'b1;
    @(posedge aclk);
    arb_lost <= 1'b0;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd_chk("control", `TWS_OFS_CONTROL, 32'h0000_0000);
    rd_chk("status", `TWS_OFS_STATUS, 32'h0000_00F8);
    rd_chk("own", `TWS_OFS_OWN_ADDR, 32'h0000_0000);
    axi_rd(8'h10, rd, rsp);
    chk("unmapped rresp", rsp, `TWS_RESP_SLVERR);
    axi_wr(8'h10, 32'h0000_00FF, rsp);
    chk("unmapped bresp", rsp, `TWS_RESP_SLVERR);
    axi_wr(`TWS_OFS_STATUS, 32'h0000_0012, rsp);
    rd_chk("status ro", `TWS_OFS_STATUS, 32'h0000_00F8);
    axi_wr(`TWS_OFS_DATA, 32'h0000_0077, rsp);
    rd_chk("collision", `TWS_OFS_CONTROL, 32'h0000_0008);
  endtask
  task automatic t_own();
    axi_wr(`TWS_OFS_OWN_ADDR, 32'h0000_00A5, rsp);
    sw(C_RUN);
    open_addr(8'hA4, 1'b0);
    post(`TWS_ST_OWN_W_ACK);
    chk("stretch", scl_oe, 1'b1);
    data_byte(8'h3C, C_ACK, 1'b0);
    post(`TWS_ST_DATA_ACK);
    rd_chk("rx byte", `TWS_OFS_DATA, 32'h0000_003C);
    data_byte(8'hC3, C_NACK, 1'b1);
    post(`TWS_ST_DATA_NACK);
    sw(C_NACK);
    i_tws_master_model.stop();
    open_addr(8'hA4, 1'b1);
    i_tws_master_model.stop();
    sw(C_RUN);
  endtask
  task automatic t_gc();
    open_addr(8'h00, 1'b0);
    post(`TWS_ST_GC_ACK);
    data_byte(8'h11, C_ACK, 1'b0);
    post(`TWS_ST_GC_DATA_ACK);
    data_byte(8'h22, C_NACK, 1'b1);
    post(`TWS_ST_GC_DATA_NACK);
    sw(C_ACK);
    i_tws_master_model.stop();
    open_addr(8'h00, 1'b0);
    post(`TWS_ST_GC_ACK);
    stop_clear(C_ACK);
    post(`TWS_ST_STOP_RSTART);
    sw(C_ACK);
  endtask
  task automatic t_refuse();
    open_addr(8'hA5, 1'b1);
    i_tws_master_model.stop();
    open_addr(8'hA6, 1'b1);
    i_tws_master_model.stop();
    axi_wr(`TWS_OFS_OWN_ADDR, 32'h0000_00A4, rsp);
    open_addr(8'h00, 1'b1);
    i_tws_master_model.stop();
    axi_wr(`TWS_OFS_OWN_ADDR, 32'h0000_00A5, rsp);
  endtask
  task automatic t_arb();
    int n;
    pulse_arb();
    open_addr(8'hA4, 1'b0);
    post(`TWS_ST_ARB_OWN_W_ACK);
    stop_clear(C_ACK);
    post(`TWS_ST_STOP_RSTART);
    launches = 0;
    sw(C_START);
    for (n = 0; n < 400 && launches == 0; n++) @(posedge aclk);
    chk("start launch", launches > 0, 1'b1);
    sw(C_RUN);
    pulse_arb();
    open_addr(8'h00, 1'b0);
    post(`TWS_ST_ARB_GC_ACK);
    stop_clear(C_ACK);
    post(`TWS_ST_STOP_RSTART);
    sw(C_ACK);
  endtask
  task automatic t_sleep();
    @(posedge aclk);
    sleep_mode <= 1'b1;
    open_addr(8'hA4, 1'b0);
    post(`TWS_ST_OWN_W_ACK);
    chk("wake", wake_req, 1'b1);
    data_byte(8'h5A, C_ACK, 1'b0);
    post(`TWS_ST_DATA_ACK);
    rd_chk("sleep data", `TWS_OFS_DATA, 32'h0000_0022);
    stop_clear(C_ACK);
    post(`TWS_ST_STOP_RSTART);
    sw(C_ACK);
    chk("asleep idle", wake_req, 1'b0);
    @(posedge aclk);
    sleep_mode <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_own();
    t_gc();
    t_refuse();
    t_arb();
    t_sleep();
    report_and_stop();
  end
endmodule // tb
